// File: bench/ppmc_bench.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module ppmc_bench;
  logic clk, nrst, cmd_valid, cmd_ready, cmd_io, cmd_write, rsp_valid, rsp_claim;
  logic bus_reset, wake_seen, wake_event, hp_wr, hp_rd, d3_exit_reset;
  logic [31:0] cmd_addr, cmd_wdata, rsp_data, hp_index, hp_wdata, hp_rdata;
  logic [3:0] cmd_be;
  logic [1:0] power_state;
  int num_errors = 0;
  int checks_done = 0;
  ppmc_if i_ppmc_if();
  ppmc_host i_ppmc_host (.clk(clk), .nrst(nrst), .bus(i_ppmc_if.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_io(cmd_io), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_be(cmd_be), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_claim(rsp_claim),
    .rsp_data(rsp_data), .bus_reset(bus_reset), .wake_seen(wake_seen));
  ppmc_device i_ppmc_device (.clk(clk), .nrst(nrst), .bus(i_ppmc_if.dev), .wake_event(wake_event),
    .hp_index(hp_index), .hp_wr(hp_wr), .hp_wdata(hp_wdata), .hp_rd(hp_rd), .hp_rdata(hp_rdata),
    .power_state(power_state), .d3_exit_reset(d3_exit_reset));
  ppmc_props i_ppmc_props (.clk(clk), .nrst(nrst), .req(i_ppmc_if.req), .is_io(i_ppmc_if.is_io),
    .write(i_ppmc_if.write), .addr(i_ppmc_if.addr), .be(i_ppmc_if.be), .wdata(i_ppmc_if.wdata),
    .bus_rst(i_ppmc_if.bus_rst), .ack(i_ppmc_if.ack), .claim(i_ppmc_if.claim),
    .rdata(i_ppmc_if.rdata), .wake(i_ppmc_if.wake));
  int wr_pulses = 0;
  int rd_pulses = 0;
  int d3_pulses = 0;
  // one-cycle strobes of the device end are counted, since no task sees them stand
  always @(posedge clk) begin
    if (hp_wr === 1'b1) wr_pulses++;
    if (hp_rd === 1'b1) rd_pulses++;
    if (d3_exit_reset === 1'b1) d3_pulses++;
  end
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one command, entered just after an edge while the host is idle
  task automatic acc(input logic io, input logic wr, input logic [31:0] a, input logic [3:0] b,
      input logic [31:0] d);
    int n;
    cmd_io = io;
    cmd_write = wr;
    cmd_addr = a;
    cmd_be = b;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20) begin
      num_errors++;
      final_report();
    end
  endtask : acc
  task automatic rd(input logic io, input logic [31:0] a, input logic [31:0] e, input logic c,
      input string nm);
    acc(io, 1'b0, a, 4'hF, 32'h0000_0000);
    chk(nm, rsp_data, e);
    chk("claim", {31'h0, rsp_claim}, {31'h0, c});
  endtask : rd
  // wake source high for one cycle, then time to settle
  task automatic pulse();
    wake_event = 1'b1;
    @(posedge clk);
    #1 wake_event = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_state();
    rd(1'b0, 32'h50, 32'h0011_0000, 1'b1, "caps");
    rd(1'b0, 32'h54, 32'h0000_0000, 1'b1, "csr_rst");
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b1, 32'h54, 4'h1, 32'(i));
      rd(1'b0, 32'h54, 32'(i), 1'b1, "state");
      chk("power_state", {30'h0, power_state}, 32'(i));
    end
    // all ones: only state and enable stick, status was clear
    acc(1'b0, 1'b1, 32'h54, 4'hF, 32'hFFFF_FFFF);
    rd(1'b0, 32'h54, 32'h0000_0103, 1'b1, "csr_ro");
    $display("t_state done");
  endtask : t_state
  task automatic t_window();
    acc(1'b0, 1'b1, 32'h58, 4'hF, 32'hFFFF_FFFF);
    rd(1'b0, 32'h58, 32'hFFFF_FFFE, 1'b1, "base_all");
    acc(1'b0, 1'b1, 32'h58, 4'hF, 32'h0000_1000);
    rd(1'b1, 32'h1000, 32'hFFFF_FFFF, 1'b0, "io_off");
    acc(1'b0, 1'b1, 32'h04, 4'h1, 32'h0000_0001);
    acc(1'b1, 1'b1, 32'h1000, 4'hF, 32'h0000_0044);
    rd(1'b1, 32'h1000, 32'h0000_0044, 1'b1, "index");
    chk("hp_index", hp_index, 32'h0000_0044);
    rd(1'b1, 32'h1001, 32'hA5A5_5A5A, 1'b1, "data");
    acc(1'b1, 1'b1, 32'h1001, 4'hF, 32'h1234_5678);
    chk("claim_dw", {31'h0, rsp_claim}, 32'h1);
    chk("hp_wdata", hp_wdata, 32'h1234_5678);
    chk("hp_wr", wr_pulses, 1);
    chk("hp_rd", rd_pulses, 1);
    // a zero base closes the window even with i/o decode on
    acc(1'b0, 1'b1, 32'h58, 4'hF, 32'h0000_0000);
    rd(1'b1, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0, "io_base0");
    chk("hp_rd_base0", rd_pulses, 1);
    acc(1'b0, 1'b1, 32'h58, 4'hF, 32'h0000_1000);
    $display("t_window done");
  endtask : t_window
  // leaving d3hot: command clears, base and power registers stay
  task automatic t_d3();
    acc(1'b0, 1'b1, 32'h54, 4'h3, 32'h0000_0100);
    repeat (3) @(posedge clk);
    #1;
    rd(1'b0, 32'h04, 32'h0000_0000, 1'b1, "cmd");
    chk("d3_pulse", d3_pulses, 1);
    chk("index_kept", hp_index, 32'h0000_0044);
    rd(1'b0, 32'h58, 32'h0000_1000, 1'b1, "base");
    rd(1'b0, 32'h54, 32'h0000_0100, 1'b1, "csr_kept");
    rd(1'b1, 32'h1000, 32'hFFFF_FFFF, 1'b0, "io_cmd_off");
    $display("t_d3 done");
  endtask : t_d3
  task automatic t_wake();
    pulse();
    chk("wake", {31'h0, wake_seen}, 32'h1);
    acc(1'b0, 1'b1, 32'h54, 4'h2, 32'h0000_0100);
    rd(1'b0, 32'h54, 32'h0000_8100, 1'b1, "sts_w0");
    bus_reset = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("cmd_ready_rst", {31'h0, cmd_ready}, 32'h0);
    bus_reset = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("cmd_ready_idle", {31'h0, cmd_ready}, 32'h1);
    rd(1'b0, 32'h54, 32'h0000_8100, 1'b1, "sts_busrst");
    acc(1'b0, 1'b1, 32'h54, 4'h2, 32'h0000_8100);
    rd(1'b0, 32'h54, 32'h0000_0100, 1'b1, "sts_w1");
    chk("wake_clr", {31'h0, wake_seen}, 32'h0);
    acc(1'b0, 1'b1, 32'h54, 4'h2, 32'h0000_0000);
    pulse();
    chk("wake_off", {31'h0, wake_seen}, 32'h0);
    rd(1'b0, 32'h54, 32'h0000_8000, 1'b1, "sts_noen");
    $display("t_wake done");
  endtask : t_wake
  // global reset in mid-run: status still set, so its clearing shows
  task automatic t_global_reset();
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    rd(1'b0, 32'h54, 32'h0000_0000, 1'b1, "csr_global_reset");
    chk("wake_global_reset", {31'h0, wake_seen}, 32'h0);
    $display("t_global_reset done");
  endtask : t_global_reset
  // main sequence: reset held ten cycles, inputs moved 1 ns after edges
  initial begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_io = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 32'h0000_0000;
    cmd_be = 4'h0;
    cmd_wdata = 32'h0000_0000;
    bus_reset = 1'b0;
    wake_event = 1'b0;
    hp_rdata = 32'hA5A5_5A5A;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    t_state();
    t_window();
    t_d3();
    t_wake();
    t_global_reset();
    final_report();
  end
endmodule : ppmc_bench
`default_nettype wire

// File: bench/ppmc_props.sv
// assertions on the link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module ppmc_props (
  // clock and global reset
  input wire logic clk,
  input wire logic nrst,
  // link signals
  input wire logic req,
  input wire logic is_io,
  input wire logic write,
  input wire logic [31:0] addr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic bus_rst,
  input wire logic ack,
  input wire logic claim,
  input wire logic [31:0] rdata,
  input wire logic wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // config read of one dword, answered on the next cycle
  sequence cfg_rd(logic [5:0] dw);
    req && !ack && !is_io && !write && addr[7:2] == dw ##1 ack;
  endsequence
  // ****************************************************************
  // link handshake
  // ****************************************************************
  a_ack_single: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  a_ack_on_take: assert property (req && !ack && !bus_rst |=> ack) else $error("ack not next cycle");
  a_ack_has_req: assert property (ack |-> $past(req)) else $error("ack without request");
  // ****************************************************************
  // register contents
  // ****************************************************************
  a_cap_word: assert property (cfg_rd(6'h14) |-> rdata == 32'h0011_0000)
    else $error("capability word wrong");
  a_csr_zero_bits: assert property (cfg_rd(6'h15) |-> rdata[14:9] == 6'h00 && rdata[7:2] == 6'h00)
    else $error("control/status fixed bits not zero");
  a_base_bit0: assert property (cfg_rd(6'h16) |-> rdata[0] == 1'b0)
    else $error("base bit 0 not zero");
  a_config_claimed: assert property (ack && !$past(is_io) |-> claim) else $error("config not claimed");
  a_io_miss_data: assert property (ack && !claim |-> rdata == 32'hFFFF_FFFF)
    else $error("unclaimed answer data wrong");
  // wake survives bus reset since status and enable both stay
  a_wake_busrst: assert property (bus_rst && wake |=> wake)
    else $error("wake lost in bus reset");
  // main scenarios
  c_io_hit: cover property (ack && claim && $past(is_io));
  c_io_miss: cover property (ack && !claim);
  c_wake_rst: cover property (bus_rst && wake);
endmodule : ppmc_props
`default_nettype wire

// File: hdl/ppmc_device.sv
// device end: power management and i/o window registers
//
// What this block does
// - capability bits 8..6 read zero
// - device specific init bit reads 0
// - aux supply required bit reads 1
// - wake needs clock bit reads 0
// - capability version field reads 001
// - control/status kept over d3hot exit reset
// - d3hot exit resets standard registers only
// - wake event sets status regardless of enable
// - write one clears status and wake
// - status survives bus reset, global clears
// - data scale/select fields read zero
// - wake enable gates wake output
// - wake enable cleared by software write or global reset only
// - control/status bits 7..2 read zero
// - power state field readable and writable
// - base hits index, base+1 hits data
// - base bit 0 reads zero
// - window valid only with nonzero base
// - host initialises base; device stores bits
`timescale 1ns/1ps
`default_nettype none
module ppmc_device (
  // clock and global reset
  input wire logic clk,
  input wire logic nrst,
  // host link
  ppmc_if.dev bus,
  // wake source inside the function
  input wire logic wake_event,
  // host-port control register access
  output logic [31:0] hp_index,
  output logic hp_wr,
  output logic [31:0] hp_wdata,
  output logic hp_rd,
  input wire logic [31:0] hp_rdata,
  // state seen by the rest of the chip
  output logic [1:0] power_state,
  output logic d3_exit_reset
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] pstate;
    logic wake_en;
    logic [31:1] base;
    logic [2:0] cmd;
    logic [31:0] index;
    logic ack;
    logic claim;
    logic [31:0] rdata;
    logic hp_wr;
    logic [31:0] hp_wdata;
    logic int_rst;
  } ppmc_dev_st_t;
  ppmc_dev_st_t st_q, st_d;
  logic wake_sts;
  logic wake_clr;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // merge write data into a register under byte enables
  function automatic logic [31:0] ppmc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : ppmc_merge

  // capability upper half: everything not listed reads zero
  function automatic logic [15:0] ppmc_cap_word();
    logic [15:0] c;
    c = 16'h0000;
    c[ppmc_pkg::CAP_VERSION_LSB +: 3] = ppmc_pkg::CAP_VERSION;
    c[ppmc_pkg::CAP_CLOCK_BIT] = ppmc_pkg::CAP_WAKE_CLOCK;
    c[ppmc_pkg::CAP_AUX_BIT] = ppmc_pkg::CAP_AUX_SUPPLY;
    c[ppmc_pkg::CAP_DSI_BIT] = ppmc_pkg::CAP_DSI;
    return c;
  endfunction : ppmc_cap_word

  // ****************************************************************
  // decode
  // ****************************************************************
  logic take;
  logic cfg_acc;
  logic win_ok;
  logic hit_index;
  logic hit_data;
  logic [7:0] cfg_dw;
  logic [15:0] csr_word;
  logic [31:0] base_word;

  // a request is taken once; the cycle after the answer it is dropped;
  // nothing is taken in bus reset, so no write slips through it
  assign take = bus.req && !st_q.ack && !bus.bus_rst;
  assign cfg_acc = take && !bus.is_io;
  assign cfg_dw = {bus.addr[7:2], 2'b00};
  // window is live only once a nonzero base is stored and i/o decode on
  assign win_ok = (st_q.base != 31'h0) && st_q.cmd[ppmc_pkg::CMD_IO_EN_BIT];
  assign hit_index = take && bus.is_io && win_ok && (bus.addr == base_word);
  assign hit_data = take && bus.is_io && win_ok &&
                    (bus.addr == base_word + ppmc_pkg::IO_DATA_STEP);
  assign base_word = {st_q.base, 1'b0};

  // control/status image; fields not assigned stay zero
  always_comb begin
    csr_word = 16'h0000;
    csr_word[ppmc_pkg::CSR_STATE_LSB +: 2] = st_q.pstate;
    csr_word[ppmc_pkg::CSR_WAKE_EN_BIT] = st_q.wake_en;
    csr_word[ppmc_pkg::CSR_WAKE_STS_BIT] = wake_sts;
  end

  // write of one to the status bit clears it; zero does nothing
  assign wake_clr = cfg_acc && bus.write && bus.be[1] &&
                    (bus.addr[7:2] == ppmc_pkg::PM_CSR_OFF[7:2]) &&
                    bus.wdata[ppmc_pkg::CSR_WAKE_STS_BIT];

  ppmc_wake_flag u_wake (
    .clk(clk),
    .nrst(nrst),
    .set(wake_event),
    .clr(wake_clr),
    .flag(wake_sts)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  // one access per request; the answer is registered one cycle later
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    st_d = st_q;
    st_d.ack = take;
    st_d.hp_wr = 1'b0;
    st_d.int_rst = 1'b0;
    if (take) begin
      st_d.claim = 1'b0;
      st_d.rdata = 32'h0000_0000;
    end
    if (cfg_acc) begin
      st_d.claim = 1'b1;
      case (cfg_dw)
        ppmc_pkg::CMD_OFF: begin
          st_d.rdata = {29'h0, st_q.cmd};
          if (bus.write && bus.be[0]) begin
            st_d.cmd = bus.wdata[2:0];
          end
        end
        {ppmc_pkg::PM_CAP_OFF[7:2], 2'b00}: begin
          st_d.rdata = {ppmc_cap_word(), 16'h0000};
        end
        ppmc_pkg::PM_CSR_OFF: begin
          st_d.rdata = {16'h0000, csr_word};
          if (bus.write && bus.be[0]) begin
            st_d.pstate = bus.wdata[ppmc_pkg::CSR_STATE_LSB +: 2];
            // leaving d3hot for d0 fires the internal reset
            st_d.int_rst = (st_q.pstate == ppmc_pkg::PS_D3HOT) &&
                           (bus.wdata[1:0] == ppmc_pkg::PS_D0);
          end
          if (bus.write && bus.be[1]) begin
            st_d.wake_en = bus.wdata[ppmc_pkg::CSR_WAKE_EN_BIT];
          end
        end
        ppmc_pkg::IO_BASE_OFF: begin
          st_d.rdata = base_word;
          if (bus.write) begin
            m = ppmc_merge(base_word, bus.wdata, bus.be);
            st_d.base = m[31:1];
          end
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end else if (hit_index) begin
      st_d.claim = 1'b1;
      st_d.rdata = st_q.index;
      if (bus.write) begin
        st_d.index = ppmc_merge(st_q.index, bus.wdata, bus.be);
      end
    end else if (hit_data) begin
      st_d.claim = 1'b1;
      st_d.rdata = bus.write ? 32'h0000_0000 : hp_rdata;
      st_d.hp_wr = bus.write;
      if (bus.write) begin
        st_d.hp_wdata = bus.wdata;
      end
    end else if (take) begin
      // unclaimed i/o reads float high on the bus
      st_d.rdata = ppmc_pkg::IO_MISS_DATA;
    end
    // d3hot exit clears only the standard command register; power
    // management, base and index registers keep their values
    if (st_q.int_rst) begin
      st_d.cmd = ppmc_pkg::CMD_RST;
    end
    // bus reset: state, command and base go; wake enable stays
    if (bus.bus_rst) begin
      st_d.pstate = ppmc_pkg::PS_D0;
      st_d.cmd = ppmc_pkg::CMD_RST;
      st_d.base = ppmc_pkg::IO_BASE_RST[31:1];
      st_d.ack = 1'b0;
      st_d.claim = 1'b0;
      st_d.hp_wr = 1'b0;
      st_d.int_rst = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign bus.ack = st_q.ack;
  assign bus.claim = st_q.claim;
  assign bus.rdata = st_q.rdata;
  // wake only while enabled; clearing status releases it
  assign bus.wake = wake_sts && st_q.wake_en;
  assign hp_index = st_q.index;
  assign hp_wr = st_q.hp_wr;
  assign hp_wdata = st_q.hp_wdata;
  // read strobe is combinational so the data lands with this access
  assign hp_rd = hit_data && !bus.write;
  assign power_state = st_q.pstate;
  assign d3_exit_reset = st_q.int_rst;
endmodule : ppmc_device
`default_nettype wire

// File: hdl/ppmc_host.sv
// host end: issues configuration and i/o accesses over the link
`timescale 1ns/1ps
`default_nettype none
module ppmc_host (
  // clock and global reset
  input wire logic clk,
  input wire logic nrst,
  // host link
  ppmc_if.host bus,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_io,
  input wire logic cmd_write,
  input wire logic [31:0] cmd_addr,
  input wire logic [3:0] cmd_be,
  input wire logic [31:0] cmd_wdata,
  // answer port
  output logic rsp_valid,
  output logic rsp_claim,
  output logic [31:0] rsp_data,
  // reset and wake
  input wire logic bus_reset,
  output logic wake_seen
);
  typedef enum {PPMC_IDLE, PPMC_WAIT} ppmc_host_state_t;
  typedef struct packed {
    ppmc_host_state_t fsm;
    logic is_io;
    logic write;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic rsp;
    logic claim;
    logic [31:0] data;
  } ppmc_host_st_t;
  ppmc_host_st_t st_q, st_d;

  // ****************************************************************
  // request sequencer
  // ****************************************************************
  // one access outstanding; the device holds bit 0 of the base at zero;
  // software writes one to the status bit to clear it
  always_comb begin
    st_d = st_q;
    st_d.rsp = 1'b0;
    case (st_q.fsm)
      PPMC_IDLE: begin
        if (cmd_valid && !bus_reset) begin
          st_d.fsm = PPMC_WAIT;
          st_d.is_io = cmd_io;
          st_d.write = cmd_write;
          st_d.addr = cmd_addr;
          st_d.be = cmd_be;
          st_d.wdata = cmd_wdata;
        end
      end
      PPMC_WAIT: begin
        if (bus.ack) begin
          st_d.fsm = PPMC_IDLE;
          st_d.rsp = 1'b1;
          st_d.claim = bus.claim;
          st_d.data = bus.rdata;
        end else if (bus_reset) begin
          st_d.fsm = PPMC_IDLE;
        end
      end
      default: begin
        st_d.fsm = PPMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cmd_ready = (st_q.fsm == PPMC_IDLE) && !bus_reset;
  assign bus.req = (st_q.fsm == PPMC_WAIT);
  assign bus.is_io = st_q.is_io;
  assign bus.write = st_q.write;
  assign bus.addr = st_q.addr;
  assign bus.be = st_q.be;
  assign bus.wdata = st_q.wdata;
  assign bus.bus_rst = bus_reset;
  assign rsp_valid = st_q.rsp;
  assign rsp_claim = st_q.claim;
  assign rsp_data = st_q.data;
  assign wake_seen = bus.wake;
endmodule : ppmc_host
`default_nettype wire

// File: hdl/ppmc_if.sv
// link between the host end and the device end of the register block
`timescale 1ns/1ps
`default_nettype none
interface ppmc_if;
  logic req;        // host: access pending
  logic is_io;      // host: 1 = i/o space, 0 = configuration space
  logic write;      // host: 1 = write
  logic [31:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic bus_rst;    // host: synchronous bus reset, level
  logic ack;        // device: one-cycle answer
  logic claim;      // device: access was decoded
  logic [31:0] rdata;
  logic wake;       // device: wake request level
  modport dev (input req, is_io, write, addr, be, wdata, bus_rst,
               output ack, claim, rdata, wake);
  modport host (output req, is_io, write, addr, be, wdata, bus_rst,
                input ack, claim, rdata, wake);
endinterface : ppmc_if
`default_nettype wire

// File: hdl/ppmc_pkg.sv
// constants used by the device end of the power management register block
package ppmc_pkg;
  // ****************************************************************
  // configuration offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CMD_OFF = 8'h04;
  localparam logic [7:0] PM_CAP_OFF = 8'h52;
  localparam logic [7:0] PM_CSR_OFF = 8'h54;
  localparam logic [7:0] IO_BASE_OFF = 8'h58;
  // byte offset of the data register from the index register
  localparam logic [31:0] IO_DATA_STEP = 32'h0000_0001;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CMD_IO_EN_BIT = 0;
  localparam int CSR_STATE_LSB = 0;
  localparam int CSR_WAKE_EN_BIT = 8;
  localparam int CSR_WAKE_STS_BIT = 15;
  localparam int CAP_VERSION_LSB = 0;
  localparam int CAP_CLOCK_BIT = 3;
  localparam int CAP_AUX_BIT = 4;
  localparam int CAP_DSI_BIT = 5;
  // ****************************************************************
  // fixed values and reset values
  // ****************************************************************
  localparam logic [2:0] CAP_VERSION = 3'h1;
  localparam logic CAP_AUX_SUPPLY = 1'b1;
  localparam logic CAP_WAKE_CLOCK = 1'b0;
  localparam logic CAP_DSI = 1'b0;
  localparam logic [31:0] IO_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] IO_MISS_DATA = 32'hFFFF_FFFF;
  localparam logic [2:0] CMD_RST = 3'h0;
  // ****************************************************************
  // power states
  // ****************************************************************
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3HOT = 2'h3;
endpackage : ppmc_pkg

// File: hdl/ppmc_wake_flag.sv
// sticky wake status flag, cleared by software or global reset only
`timescale 1ns/1ps
`default_nettype none
module ppmc_wake_flag (
  // clock and global reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic flag
);
  typedef struct packed {
    logic sts;
  } ppmc_flag_st_t;
  ppmc_flag_st_t st_q, st_d;

  // set beats clear so a wake arriving during the clear is not lost
  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.sts = 1'b0;
    end
    if (set) begin
      st_d.sts = 1'b1;
    end
  end

  // bus reset is not an input here: only the global reset clears it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag = st_q.sts;
endmodule : ppmc_wake_flag
`default_nettype wire
